// [inc/pma_pkg.sv]
// Functional notes
// - target registers ignore writes while busy
// - only the owning side writes target registers
// - select bit picks port 0 or indexed port
// - port 0 address is the consecutive base
// - register select keeps five bits, rest zero
// - claim bit blocks host side takeover
// - network writes claim only while host bit clear
// - host bit shows owner, host writes it
// - force bit clears host ownership
// - host takeover needs claim and force clear
// - legacy builds also need eeprom loaded
// - command field starts read or write
// - busy stays set while a transaction runs
package pma_pkg;
   localparam logic [15:0] ADDR_CTRL_LO = 16'h0510;
   localparam logic [15:0] ADDR_CTRL_HI = 16'h0511;
   localparam logic [15:0] ADDR_PHY_ADDR = 16'h0512;
   localparam logic [15:0] ADDR_REG_SEL = 16'h0513;
   localparam logic [15:0] ADDR_DATA_LO = 16'h0514;
   localparam logic [15:0] ADDR_DATA_HI = 16'h0515;
   localparam logic [15:0] ADDR_CLAIM = 16'h0516;
   localparam logic [15:0] ADDR_OWNER = 16'h0517;
   localparam int NUM_BYTES = 8;
   localparam int PHY_ADDR_MSB = 4;
   localparam int DISP_SEL_BIT = 7;
   localparam int CTRL_FIELD_LSB = 3;
   localparam int CTRL_PDI_POSSIBLE_BIT = 1;
   localparam int CMD_LSB = 0;
   localparam int BUSY_BIT = 7;
   localparam int OWN_BIT = 0;
   localparam int FORCE_BIT = 1;
   localparam int CLAIM_BIT = 0;
   localparam int NUM_PORTS = 4;
   localparam logic [1:0] CMD_IDLE = 2'h0;
   localparam logic [1:0] CMD_READ = 2'h1;
   localparam logic [1:0] CMD_WRITE = 2'h2;
   localparam logic [4:0] RST_FIELD5 = 5'h00;
   localparam logic [15:0] RST_DATA = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// [rtl/pma_side_port.sv]
`timescale 1ns/100ps
// byte access port of one side: decode and registered read
module pma_side_port (
   input wire logic mclk_in, // clock
   input wire logic rstn_in, // async reset, low
   input wire logic [15:0] addr_in, // byte address
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   input wire logic [8*pma_pkg::NUM_BYTES-1:0] image_in, // register bytes, 0x510 lowest
   output logic [pma_pkg::NUM_BYTES-1:0] wr_hit_out, // one-hot write decode
   output logic [7:0] rdata_out // read data
);
   typedef struct packed {
      logic [7:0] rdata;
   } pma_port_state_type;
   pma_port_state_type st_r, st_nxt;
   logic in_window;
   logic [2:0] idx;

   assign in_window = (addr_in[15:3] == pma_pkg::ADDR_CTRL_LO[15:3]);
   assign idx = addr_in[2:0];

   always_comb begin
      wr_hit_out = '0;
      if (wr_in && in_window) begin
         wr_hit_out[idx] = 1'b1;
      end
   end

   always_comb begin
      st_nxt = st_r;
      if (rd_in) begin
         st_nxt.rdata = in_window ? image_in[8*idx +: 8] : pma_pkg::RST_BYTE;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out = st_r.rdata;
endmodule

// [rtl/pma_addr_display.sv]
`timescale 1ns/100ps
// phy_target_address shown in the control/status field
module pma_addr_display #(
   parameter int NUM_PORTS = pma_pkg::NUM_PORTS
) (
   input wire logic disp_sel_in, // 1: show indexed port
   input wire logic [4:0] index_in, // port index from target address
   input wire logic [5*NUM_PORTS-1:0] port_phy_addr_in, // configured per-port addresses
   output logic [4:0] field_out // displayed address
);
   always_comb begin
      field_out = port_phy_addr_in[4:0];
      if (disp_sel_in) begin
         if (int'(index_in) < NUM_PORTS) begin
            field_out = port_phy_addr_in[5*index_in +: 5];
         end else begin
            field_out = pma_pkg::RST_FIELD5;
         end
      end
   end
endmodule

// [rtl/pma_mgmt_arbiter.sv]
`timescale 1ns/100ps
// management target registers and ownership arbitration
module pma_mgmt_arbiter #(
   parameter bit LEGACY_EEPROM_GATE = 1'b0,
   parameter int NUM_PORTS = pma_pkg::NUM_PORTS
) (
   input wire logic mclk_in, // clock, 100 MHz
   input wire logic rstn_in, // async reset, low
   input wire logic [15:0] net_addr_in, // network side byte address
   input wire logic net_wr_in, // network side write strobe
   input wire logic net_rd_in, // network side read strobe
   input wire logic [7:0] net_wdata_in, // network side write byte
   output logic [7:0] net_rdata_out, // network side read byte
   input wire logic [15:0] host_addr_in, // host side byte address
   input wire logic host_wr_in, // host side write strobe
   input wire logic host_rd_in, // host side read strobe
   input wire logic [7:0] host_wdata_in, // host side write byte
   output logic [7:0] host_rdata_out, // host side read byte
   input wire logic eeprom_loaded_in, // config eeprom loaded flag
   input wire logic [5*NUM_PORTS-1:0] port_phy_addr_in, // configured phy addresses
   output logic mi_start_out, // start pulse to serial engine
   output logic [1:0] mi_cmd_out, // command being executed
   output logic [4:0] mi_phy_addr_out, // target phy_target_address
   output logic [4:0] mi_reg_out, // target phy register
   output logic [15:0] mi_wdata_out, // word to write
   input wire logic mi_done_in, // engine finished, one pulse
   input wire logic [15:0] mi_rdata_in, // word read from phy
   output logic busy_out, // transaction running
   output logic host_owns_out // 1: host side owns interface
);
   typedef struct packed {
      logic [4:0] phy_addr;
      logic disp_sel;
      logic [4:0] reg_sel;
      logic [15:0] data;
      logic claim;
      logic host_own;
      logic force_back;
      logic [1:0] cmd;
      logic busy;
      logic start;
   } pma_state_type;

   pma_state_type st_r, st_nxt;
   logic [8*pma_pkg::NUM_BYTES-1:0] image;
   logic [pma_pkg::NUM_BYTES-1:0] net_hit, host_hit, own_hit;
   logic [7:0] own_wdata;
   logic [4:0] disp_field;
   logic tgt_open;
   logic takeover_ok;

   pma_side_port u_net_port (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .addr_in(net_addr_in),
      .wr_in(net_wr_in),
      .rd_in(net_rd_in),
      .image_in(image),
      .wr_hit_out(net_hit),
      .rdata_out(net_rdata_out)
   );

   pma_side_port u_host_port (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .addr_in(host_addr_in),
      .wr_in(host_wr_in),
      .rd_in(host_rd_in),
      .image_in(image),
      .wr_hit_out(host_hit),
      .rdata_out(host_rdata_out)
   );

   pma_addr_display #(
      .NUM_PORTS(NUM_PORTS)
   ) u_display (
      .disp_sel_in(st_r.disp_sel),
      .index_in(st_r.phy_addr),
      .port_phy_addr_in(port_phy_addr_in),
      .field_out(disp_field)
   );

   // register image as both sides read it
   always_comb begin
      image = '0;
      image[8*0 + pma_pkg::CTRL_FIELD_LSB +: 5] = disp_field;
      image[8*0 + pma_pkg::CTRL_PDI_POSSIBLE_BIT] = 1'b1;
      image[8*1 + pma_pkg::CMD_LSB +: 2] = st_r.cmd;
      image[8*1 + pma_pkg::BUSY_BIT] = st_r.busy;
      image[8*2 +: 5] = st_r.phy_addr;
      image[8*2 + pma_pkg::DISP_SEL_BIT] = st_r.disp_sel;
      image[8*3 +: 5] = st_r.reg_sel;
      image[8*4 +: 16] = st_r.data;
      image[8*6 + pma_pkg::CLAIM_BIT] = st_r.claim;
      image[8*7 + pma_pkg::OWN_BIT] = st_r.host_own;
      image[8*7 + pma_pkg::FORCE_BIT] = st_r.force_back;
   end

   // the owner's write port; the other side is shut out
   assign own_hit = st_r.host_own ? host_hit : net_hit;
   assign own_wdata = st_r.host_own ? host_wdata_in : net_wdata_in;
   assign tgt_open = !st_r.busy;
   assign takeover_ok = !st_r.claim && !st_r.force_back
      && (!LEGACY_EEPROM_GATE || eeprom_loaded_in);

   always_comb begin
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      // target registers
      if (tgt_open) begin
         if (own_hit[2]) begin
            st_nxt.phy_addr = own_wdata[pma_pkg::PHY_ADDR_MSB:0];
            st_nxt.disp_sel = own_wdata[pma_pkg::DISP_SEL_BIT];
         end
         if (own_hit[3]) begin
            st_nxt.reg_sel = own_wdata[4:0];
         end
         if (own_hit[4]) begin
            st_nxt.data[7:0] = own_wdata;
         end
         if (own_hit[5]) begin
            st_nxt.data[15:8] = own_wdata;
         end
         // command issue
         if (own_hit[1]) begin
            case (own_wdata[pma_pkg::CMD_LSB +: 2])
               pma_pkg::CMD_READ, pma_pkg::CMD_WRITE: begin
                  st_nxt.cmd = own_wdata[pma_pkg::CMD_LSB +: 2];
                  st_nxt.busy = 1'b1;
                  st_nxt.start = 1'b1;
               end
               pma_pkg::CMD_IDLE: begin
                  st_nxt.cmd = pma_pkg::CMD_IDLE;
               end
               default: begin
                  st_nxt.cmd = st_r.cmd;
               end
            endcase
         end
      end
      // completion of a running transaction
      if (st_r.busy && mi_done_in) begin
         st_nxt.busy = 1'b0;
         st_nxt.cmd = pma_pkg::CMD_IDLE;
         if (st_r.cmd == pma_pkg::CMD_READ) begin
            st_nxt.data = mi_rdata_in;
         end
      end
      // network side claim and force
      if (net_hit[6] && !st_r.host_own) begin
         st_nxt.claim = net_wdata_in[pma_pkg::CLAIM_BIT];
      end
      if (net_hit[7]) begin
         st_nxt.force_back = net_wdata_in[pma_pkg::FORCE_BIT];
      end
      // host side ownership
      if (host_hit[7]) begin
         if (!host_wdata_in[pma_pkg::OWN_BIT]) begin
            st_nxt.host_own = 1'b0;
         end else if (takeover_ok) begin
            st_nxt.host_own = 1'b1;
         end
      end
      if (st_r.force_back) begin
         st_nxt.host_own = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign mi_start_out = st_r.start;
   assign mi_cmd_out = st_r.cmd;
   assign mi_phy_addr_out = st_r.phy_addr;
   assign mi_reg_out = st_r.reg_sel;
   assign mi_wdata_out = st_r.data;
   assign busy_out = st_r.busy;
   assign host_owns_out = st_r.host_own;
endmodule

// [tb/pma_phy_model.sv]
`timescale 1ns/100ps
module pma_phy_model (
   input wire logic mclk_in, // clock
   input wire logic slow_in, // long turnaround
   input wire logic start_in, // start pulse
   input wire logic [4:0] phy_in, // phy_target_address
   input wire logic [4:0] reg_in, // phy register
   output logic done_out = 1'b0, // finished pulse
   output logic [15:0] rdata_out = 16'h0000 // read word
);
   int cnt = 0;
   always @(posedge mclk_in) begin
      done_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (start_in)
         cnt <= slow_in ? 12 : 2;
      else if (cnt > 0)
         cnt <= cnt - 1;
      if (!start_in && cnt == 1) begin
         done_out <= 1'b1;
         rdata_out <= {phy_in, reg_in, 6'h15};
      end
   end
endmodule

// [tb/pma_mgmt_arbiter_chk.sv]
`timescale 1ns/100ps
module pma_mgmt_arbiter_chk (
   input wire logic mclk_in, // clock
   input wire logic rstn_in, // reset
   input wire logic [15:0] net_addr_in, // address
   input wire logic net_wr_in, // write
   input wire logic [7:0] net_wdata_in, // data
   input wire logic [15:0] host_addr_in, // address
   input wire logic host_wr_in, // write
   input wire logic mi_start_out, // start
   input wire logic [1:0] mi_cmd_out, // command
   input wire logic [4:0] mi_phy_addr_out, // phy
   input wire logic [4:0] mi_reg_out, // register
   input wire logic [15:0] mi_wdata_out, // word
   input wire logic mi_done_in, // done
   input wire logic [15:0] mi_rdata_in, // read word
   input wire logic busy_out, // busy
   input wire logic host_owns_out // owner
);
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);
   a_start_cmd: assert property (mi_start_out |-> busy_out && mi_cmd_out inside {2'h1, 2'h2})
      else $error("start without command");
   a_start_once: assert property (mi_start_out |=> !mi_start_out)
      else $error("start too long");
   a_done_idle: assert property (busy_out && mi_done_in |=> !busy_out && mi_cmd_out == 2'h0)
      else $error("busy after done");
   a_busy_hold: assert property (busy_out && !mi_done_in |=> busy_out)
      else $error("busy dropped");
   a_busy_freeze: assert property (busy_out |=> $stable(mi_phy_addr_out) && $stable(mi_reg_out))
      else $error("target changed while busy");
   a_read_load: assert property (busy_out && mi_done_in && mi_cmd_out == 2'h1
      |=> mi_wdata_out == $past(mi_rdata_in))
      else $error("read word not loaded");
   // force is registered first, ownership drops one edge later
   a_force_back: assert property (net_wr_in && net_addr_in == 16'h0517 && net_wdata_in[1]
      |-> ##2 !host_owns_out)
      else $error("force ignored");
   a_own_cause: assert property ($rose(host_owns_out) |-> $past(host_wr_in) && $past(host_addr_in) == 16'h0517)
      else $error("owner changed without host write");
   a_net_locked: assert property (host_owns_out && net_wr_in && !host_wr_in |=> $stable(mi_reg_out))
      else $error("network wrote while host owns");
endmodule
bind pma_mgmt_arbiter pma_mgmt_arbiter_chk chk (.mclk_in(mclk_in), .rstn_in(rstn_in), .net_addr_in(net_addr_in),
   .net_wr_in(net_wr_in), .net_wdata_in(net_wdata_in), .host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
   .mi_start_out(mi_start_out), .mi_cmd_out(mi_cmd_out), .mi_phy_addr_out(mi_phy_addr_out),
   .mi_reg_out(mi_reg_out), .mi_wdata_out(mi_wdata_out), .mi_done_in(mi_done_in), .mi_rdata_in(mi_rdata_in),
   .busy_out(busy_out), .host_owns_out(host_owns_out));

// [tb/pma_mgmt_arbiter_tb.sv]
`timescale 1ns/100ps
module pma_mgmt_arbiter_tb;
   logic mclk_in = 1'b0, rstn_in = 1'b0, nw = 1'b0, nr = 1'b0, hw = 1'b0, hr = 1'b0, slow = 1'b0, ee = 1'b0;
   logic [15:0] na = 16'h0000, ha = 16'h0000, wd, rdw, w;
   logic [7:0] nd = 8'h00, hd = 8'h00, nq, hq, q, t, r;
   logic [19:0] ppa = 20'h0_0000;
   logic st, dn, busy, own;
   logic [1:0] cmd, c;
   logic [4:0] pa, rg;
   int mismatches = 0, total_checks = 0, k;
   pma_mgmt_arbiter #(
      .LEGACY_EEPROM_GATE(1'b1)
   ) dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .net_addr_in(na), .net_wr_in(nw), .net_rd_in(nr),
      .net_wdata_in(nd), .net_rdata_out(nq), .host_addr_in(ha), .host_wr_in(hw), .host_rd_in(hr),
      .host_wdata_in(hd), .host_rdata_out(hq), .eeprom_loaded_in(ee), .port_phy_addr_in(ppa),
      .mi_start_out(st), .mi_cmd_out(cmd), .mi_phy_addr_out(pa), .mi_reg_out(rg), .mi_wdata_out(wd),
      .mi_done_in(dn), .mi_rdata_in(rdw), .busy_out(busy), .host_owns_out(own));
   pma_phy_model phy (.mclk_in(mclk_in), .slow_in(slow), .start_in(st), .phy_in(pa), .reg_in(rg),
      .done_out(dn), .rdata_out(rdw));
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one byte access of either side, strobe held over one rising edge
   task automatic acc(input bit h, input bit wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      {ha, hd, na, nd} = {a, d, a, d};
      {hw, hr, nw, nr} = {h & wr, h & !wr, !h & wr, !h & !wr};
      @(negedge mclk_in);
      {hw, hr, nw, nr} = 4'h0;
      q = h ? hq : nq;
   endtask
   function automatic logic [4:0] disp(input logic [7:0] s);
      return !s[7] ? ppa[4:0] : (s[4:0] > 5'h03) ? 5'h00 : ppa[5*s[1:0] +: 5];
   endfunction
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk_in);
      mismatches++;
      test_done;
   end
   initial begin
      k = $urandom(58948);
      ppa = 20'($urandom);
      repeat (10) @(negedge mclk_in);
      rstn_in = 1'b1;
      for (k = 2; k < 8; k++) begin
         acc(0, 0, 16'h0510 + 16'(k), 8'h00);
         chk(q, 16'h0000);
      end
      acc(0, 0, 16'h0510, 8'h00);
      chk(q, {ppa[4:0], 3'b010});
      $display("reset values done");
      acc(1, 1, 16'h0517, 8'h01);
      chk(own, 1'b0);
      ee = 1'b1;
      acc(1, 1, 16'h0517, 8'h01);
      chk(own, 1'b1);
      acc(0, 1, 16'h0513, 8'h07);
      acc(1, 1, 16'h0513, 8'hFF);
      acc(0, 0, 16'h0513, 8'h00);
      chk(q, 16'h001F);
      acc(0, 1, 16'h0516, 8'h01);
      acc(1, 0, 16'h0516, 8'h00);
      chk(q, 16'h0000);
      acc(0, 1, 16'h0517, 8'h02);
      // ownership falls one edge after the force bit is registered
      @(negedge mclk_in);
      chk(own, 1'b0);
      acc(1, 1, 16'h0517, 8'h01);
      chk(own, 1'b0);
      acc(0, 1, 16'h0517, 8'h00);
      acc(0, 1, 16'h0516, 8'h01);
      acc(1, 1, 16'h0517, 8'h01);
      chk(own, 1'b0);
      acc(0, 1, 16'h0516, 8'h00);
      $display("ownership done");
      for (k = 0; k < 40; k++) begin
         t = 8'($urandom) & 8'h9F;
         r = 8'($urandom);
         w = 16'($urandom);
         c = 2'(1 + $urandom % 2);
         slow = 1'($urandom);
         acc(0, 1, 16'h0512, t);
         acc(0, 0, 16'h0510, 8'h00);
         chk(q[7:3], disp(t));
         acc(0, 1, 16'h0513, r);
         acc(0, 1, 16'h0514, w[7:0]);
         acc(0, 1, 16'h0515, w[15:8]);
         acc(0, 1, 16'h0511, {6'h00, c});
         chk(busy, 1'b1);
         chk(cmd, c);
         chk(st, 1'b1);
         acc(0, 1, 16'h0512, ~t);
         for (int i = 0; i < 40 && busy !== 1'b0; i++)
            @(negedge mclk_in);
         acc(0, 0, 16'h0512, 8'h00);
         chk(q, t);
         chk(wd, c == 2'h1 ? {t[4:0], r[4:0], 6'h15} : w);
         chk(cmd, 2'h0);
      end
      acc(0, 1, 16'h0511, 8'h03);
      chk(busy, 1'b0);
      $display("transactions done");
      test_done;
   end
endmodule
